/* File: core/xhb_arbiter.sv */
// Purpose: hold request / hold grant arbitration of the expansion bus
// Assumes: pins sampled on clk; arbiter mode and direction polarity are
//          boot straps captured on the first edge after reset release
// Notes: pins are split into value, enable and input copies
// Contract
// - drain pending transactions before raising grant
// - float group at least three periods after request
// - raise grant within two periods of floating
// - drop grant three or more periods after release
// - redrive group within two periods of grant low
// - external mode: drive group two periods after grant
// - external mode: float group, then drop request
// - group is byte enables, strobe, direction, burst last
// - host-port accesses use shared lines as byte enables
// - direction polarity fixed by boot strap
// - all intervals counted in cpu clock periods
`timescale 1ns/10ps
`default_nettype none
module xhb_arbiter (
	input wire logic clk,
	input wire logic resetn,
	input wire logic strap_internal_arb,
	input wire logic strap_dir_invert,
	input wire logic bus_hold_request_i,
	output logic bus_hold_request_o,
	output logic bus_hold_request_oe,
	input wire logic bus_hold_grant_i,
	output logic bus_hold_grant_o,
	output logic bus_hold_grant_oe,
	output xhb_pkg::xhb_group_t shared_control_group_o,
	output logic shared_control_group_oe,
	input wire logic host_write_read_dir_i,
	input wire xhb_pkg::xhb_core_t core_group,
	input wire logic core_host_port_access,
	input wire logic core_xact_pending,
	input wire logic core_want_bus,
	output logic core_hold_off,
	output logic core_owns_bus,
	output logic core_host_write
);

	// counts are small; the two-bit counter must reach each of them, and
	// the one-stage grant register drives the group two periods on
	if (xhb_pkg::HZ_MIN_CYC > 3 || xhb_pkg::GRANT_DROP_MIN_CYC > 3 ||
		xhb_pkg::HZ_MIN_CYC < 1 || xhb_pkg::GRANT_DROP_MIN_CYC < 1 ||
		xhb_pkg::GRANT_MAX_CYC < 1 || xhb_pkg::REDRIVE_MAX_CYC < 1 ||
		xhb_pkg::EXT_DROP_MAX_CYC < 1 || xhb_pkg::EXT_DRIVE_MIN_CYC > 2 ||
		xhb_pkg::EXT_DRIVE_MAX_CYC < 2) begin : g_count_check
		$error("xhb_arbiter: timing counts out of range");
	end

	typedef enum logic [3:0] {
		ST_BOOT, ST_OWN, ST_DRAIN, ST_FLOAT, ST_HELD, ST_RELEASE,
		ST_REDRIVE, ST_EXT_IDLE, ST_EXT_REQ, ST_EXT_OWN, ST_EXT_FLOAT
	} xhb_state_t;

	logic req_s1_r, req_s_r;       // request synchroniser
	logic grant_s_r;               // grant register, one stage
	logic req_oe_r, req_oe_nxt;    // request pin enable
	xhb_state_t state_r, state_nxt;
	logic [1:0] cnt_r, cnt_nxt;    // period counter, saturating
	logic mode_int_r, mode_int_nxt;   // internal arbiter strap
	logic dir_inv_r, dir_inv_nxt;     // direction polarity strap
	xhb_pkg::xhb_group_t grp_r, grp_nxt;
	logic grp_oe_r, grp_oe_nxt;
	logic grant_r, grant_nxt;
	logic req_r, req_nxt;
	logic hold_off_r, hold_off_nxt;
	logic owns_r, owns_nxt;
	logic hwrite_r, hwrite_nxt;

	// request: two-flop synchroniser, first stage feeds only the second
	// grant: one stage only; the drive window leaves no room for a second
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			req_s1_r <= 1'b0;
			req_s_r <= 1'b0;
			grant_s_r <= 1'b0;
		end else begin
			req_s1_r <= bus_hold_request_i;
			req_s_r <= req_s1_r;
			grant_s_r <= bus_hold_grant_i;
		end
	end

	// next state of the arbiter and the pin drivers
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = (cnt_r == 2'h3) ? cnt_r : cnt_r + 2'h1;
		mode_int_nxt = mode_int_r;
		dir_inv_nxt = dir_inv_r;
		grp_oe_nxt = grp_oe_r;
		grant_nxt = grant_r;
		req_nxt = req_r;
		// drive the group from the core; direction takes boot polarity
		grp_nxt.host_be_addr = core_host_port_access ?
			core_group.byte_enable_n : core_group.addr_low;
		grp_nxt.host_addr_strobe_n = core_group.addr_strobe_n;
		grp_nxt.host_write_read_dir = core_group.write ^ dir_inv_r;
		grp_nxt.host_burst_last_n = core_group.burst_last_n;
		// incoming direction decoded with the same polarity
		hwrite_nxt = host_write_read_dir_i ^ dir_inv_r;
		unique case (state_r)
			// capture straps once after reset release
			ST_BOOT: begin
				mode_int_nxt = strap_internal_arb;
				dir_inv_nxt = strap_dir_invert;
				cnt_nxt = 2'h0;
				if (strap_internal_arb) begin
					grp_oe_nxt = 1'b1;
					state_nxt = ST_OWN;
				end else begin
					state_nxt = ST_EXT_IDLE;
				end
			end
			// internal arbiter: we own and drive the bus
			ST_OWN: begin
				cnt_nxt = 2'h1;
				if (req_s_r)
					state_nxt = ST_DRAIN;
			end
			// wait out pending work and the least float delay
			ST_DRAIN: begin
				if (cnt_r >= 2'(xhb_pkg::HZ_MIN_CYC - 1) &&
					!core_xact_pending) begin
					grp_oe_nxt = 1'b0;
					state_nxt = ST_FLOAT;
				end
			end
			// group floated; grant on the next edge
			ST_FLOAT: begin
				grant_nxt = 1'b1;
				state_nxt = ST_HELD;
			end
			// external master owns the bus
			ST_HELD: begin
				cnt_nxt = 2'h1;
				if (!req_s_r)
					state_nxt = ST_RELEASE;
			end
			// hold the grant for the least drop delay
			ST_RELEASE: begin
				if (req_s_r) begin
					state_nxt = ST_HELD;
				end else if (cnt_r >=
					2'(xhb_pkg::GRANT_DROP_MIN_CYC - 1)) begin
					grant_nxt = 1'b0;
					state_nxt = ST_REDRIVE;
				end
			end
			// grant low; take the group back next edge
			ST_REDRIVE: begin
				grp_oe_nxt = 1'b1;
				state_nxt = ST_OWN;
			end
			// external arbiter: idle, group floated
			ST_EXT_IDLE: begin
				if (core_want_bus) begin
					req_nxt = 1'b1;
					state_nxt = ST_EXT_REQ;
				end
			end
			// request out; drive as soon as the grant is seen
			ST_EXT_REQ: begin
				if (grant_s_r) begin
					grp_oe_nxt = 1'b1;
					state_nxt = ST_EXT_OWN;
				end
			end
			// we own the bus; give it up when done or grant lost
			ST_EXT_OWN: begin
				if (!grant_s_r || (!core_want_bus && !core_xact_pending)) begin
					grp_oe_nxt = 1'b0;
					state_nxt = ST_EXT_FLOAT;
				end
			end
			// floated first, request drops next edge
			ST_EXT_FLOAT: begin
				req_nxt = 1'b0;
				state_nxt = ST_EXT_IDLE;
			end
		endcase
		// core must not start new transfers unless it owns the bus
		owns_nxt = (state_nxt == ST_OWN) || (state_nxt == ST_EXT_OWN) ||
			(state_nxt == ST_DRAIN);
		hold_off_nxt = (state_nxt != ST_OWN) && (state_nxt != ST_EXT_OWN);
		// request pin is ours only with the outside arbiter, after boot
		req_oe_nxt = !mode_int_nxt && (state_nxt != ST_BOOT);
	end

	// registers of the arbiter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= ST_BOOT;
			cnt_r <= 2'h0;
			mode_int_r <= 1'b0;
			dir_inv_r <= 1'b0;
			grp_r <= '0;
			grp_oe_r <= xhb_pkg::RST_GROUP_OE;
			grant_r <= xhb_pkg::RST_GRANT;
			req_r <= xhb_pkg::RST_REQUEST;
			hold_off_r <= 1'b1;
			owns_r <= 1'b0;
			hwrite_r <= 1'b0;
			req_oe_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			mode_int_r <= mode_int_nxt;
			dir_inv_r <= dir_inv_nxt;
			grp_r <= grp_nxt;
			grp_oe_r <= grp_oe_nxt;
			grant_r <= grant_nxt;
			req_r <= req_nxt;
			hold_off_r <= hold_off_nxt;
			owns_r <= owns_nxt;
			hwrite_r <= hwrite_nxt;
			req_oe_r <= req_oe_nxt;
		end
	end

	// a pin is driven only in the mode where we are its source
	assign bus_hold_grant_o = grant_r;
	assign bus_hold_grant_oe = mode_int_r;
	assign bus_hold_request_o = req_r;
	assign bus_hold_request_oe = req_oe_r;
	assign shared_control_group_o = grp_r;
	assign shared_control_group_oe = grp_oe_r;
	assign core_hold_off = hold_off_r;
	assign core_owns_bus = owns_r;
	assign core_host_write = hwrite_r;

	// grant rises only after pending work has drained
	drain_first_a: assert property (@(posedge clk) disable iff (!resetn)
		$rose(grant_r) |-> !$past(core_xact_pending, 2))
		else $error("grant raised with a transaction pending");

	// group floats three periods or more after request seen
	float_delay_a: assert property (@(posedge clk) disable iff (!resetn)
		mode_int_r && $fell(grp_oe_r) |->
		$past(req_s_r, 2) && $past(req_s_r, 3))
		else $error("group floated too early after request");

	// grant follows float within two periods
	grant_rise_a: assert property (@(posedge clk) disable iff (!resetn)
		mode_int_r && $fell(grp_oe_r) |-> ##[1:2] grant_r)
		else $error("grant late after float");

	// grant drops only after request low for three periods
	grant_drop_a: assert property (@(posedge clk) disable iff (!resetn)
		$fell(grant_r) |-> !$past(req_s_r, 1) && !$past(req_s_r, 2) &&
		!$past(req_s_r, 3))
		else $error("grant dropped too early");

	// group driven again within two periods of grant low
	redrive_a: assert property (@(posedge clk) disable iff (!resetn)
		mode_int_r && $fell(grant_r) |-> ##[1:2] grp_oe_r)
		else $error("group not redriven after grant low");

	// grant is never high while we drive the group
	no_clash_a: assert property (@(posedge clk) disable iff (!resetn)
		grant_r |-> !grp_oe_r)
		else $error("grant high while group driven");

	// external mode: drive on the edge after grant seen
	ext_drive_a: assert property (@(posedge clk) disable iff (!resetn)
		!mode_int_r && $rose(grp_oe_r) |-> $past(grant_s_r) && req_r)
		else $error("group driven without grant");

	// external mode: request drops after group floats, within two
	ext_drop_a: assert property (@(posedge clk) disable iff (!resetn)
		!mode_int_r && $fell(grp_oe_r) |-> req_r ##[1:2] !req_r)
		else $error("request not dropped after float");

	// request never drops while group still driven
	ext_order_a: assert property (@(posedge clk) disable iff (!resetn)
		!mode_int_r && $fell(req_r) |-> !grp_oe_r && !$past(grp_oe_r))
		else $error("request dropped before float");

	// byte enables replace low address during host-port access
	be_mux_a: assert property (@(posedge clk) disable iff (!resetn)
		$past(resetn) && $past(core_host_port_access) |->
		grp_r.host_be_addr == $past(core_group.byte_enable_n))
		else $error("byte enables not on shared lines");

	// polarity stays fixed once captured
	dir_pol_a: assert property (@(posedge clk) disable iff (!resetn)
		$past(state_r) != ST_BOOT && state_r != ST_BOOT |-> $stable(dir_inv_r))
		else $error("direction polarity changed after boot");

	// synchronised request lags the pin by two edges
	sync_req_a: assert property (@(posedge clk) disable iff (!resetn)
		$past(resetn, 2) |-> req_s_r == $past(bus_hold_request_i, 2))
		else $error("request synchroniser depth wrong");

	// group driven no sooner than two periods after the grant pin rose
	drive_gap_a: assert property (@(posedge clk) disable iff (!resetn)
		!mode_int_r && $rose(grp_oe_r) |-> $past(bus_hold_grant_i, 2))
		else $error("group driven too soon after grant");

	// grant register follows the pin by one edge
	sync_grant_a: assert property (@(posedge clk) disable iff (!resetn)
		$past(resetn) |-> grant_s_r == $past(bus_hold_grant_i))
		else $error("grant register depth wrong");

endmodule
`default_nettype wire

/* File: core/xhb_pkg.sv */
// Purpose: shared constants and types for the expansion bus hold arbiter
// Assumes: one clock at 20 MHz; every interval but the 10 ns drive slack is a whole number of periods
// Notes: the control group fields are packed in pin order, top field first
package xhb_pkg;

	// cpu clock period in ns, and the block clock period in ns
	localparam int CPU_PERIOD_NS = 50;
	localparam int CLK_PERIOD_NS = 50;

	// least time from hold request high to group floated, in periods
	localparam int HZ_MIN_P = 3;
	// longest time from group floated to grant high, in periods
	localparam int GRANT_MAX_P = 2;
	// least time from hold request low to grant low, in periods
	localparam int GRANT_DROP_MIN_P = 3;
	// longest time from grant low to group driven again, in periods
	localparam int REDRIVE_MAX_P = 2;
	// external grant to group driven: least in periods, extra slack in ns
	localparam int EXT_DRIVE_MIN_P = 2;
	localparam int EXT_DRIVE_SLACK_NS = 10;
	// longest time from group floated to own request low, in periods
	localparam int EXT_DROP_MAX_P = 2;

	// least times round up, longest times round down, never below one
	localparam int HZ_MIN_CYC =
		(HZ_MIN_P * CPU_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GRANT_DROP_MIN_CYC =
		(GRANT_DROP_MIN_P * CPU_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GRANT_MAX_CYC = (GRANT_MAX_P * CPU_PERIOD_NS) / CLK_PERIOD_NS;
	localparam int REDRIVE_MAX_CYC =
		(REDRIVE_MAX_P * CPU_PERIOD_NS) / CLK_PERIOD_NS;
	localparam int EXT_DRIVE_MIN_CYC =
		(EXT_DRIVE_MIN_P * CPU_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXT_DRIVE_MAX_CYC =
		(EXT_DRIVE_MIN_P * CPU_PERIOD_NS + EXT_DRIVE_SLACK_NS) / CLK_PERIOD_NS;
	localparam int EXT_DROP_MAX_CYC =
		(EXT_DROP_MAX_P * CPU_PERIOD_NS) / CLK_PERIOD_NS;

	// reset values of the pin drivers
	localparam logic RST_GROUP_OE = 1'b0;
	localparam logic RST_GRANT = 1'b0;
	localparam logic RST_REQUEST = 1'b0;

	// values the core wants on the control group
	typedef struct packed {
		logic [3:0] byte_enable_n;   // byte enables, active low
		logic [3:0] addr_low;        // low word address bits
		logic addr_strobe_n;         // address strobe, active low
		logic write;                 // 1 = write, before polarity
		logic burst_last_n;          // last beat of burst, active low
	} xhb_core_t;

	// the shared control group as it leaves the pins
	typedef struct packed {
		logic [3:0] host_be_addr;    // byte enables or low address
		logic host_addr_strobe_n;    // address strobe
		logic host_write_read_dir;   // direction, boot polarity applied
		logic host_burst_last_n;     // burst last, always active low
	} xhb_group_t;

endpackage

/* File: test/tb_top.sv */
// Purpose: random and corner tests of the hold arbiter in both modes
// Assumes: straps change only under reset; released pins read low
// Notes: event times are sample indices of the clk rising edge
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
	logic clk, resetn, s_int, s_inv, dir_i, hp, pend, want, go, chk_en;
	logic rq_o, rq_oe, gr_o, gr_oe, oe, p_rq, p_rq_oe, p_gr, p_gr_oe;
	logic hold_off, owns, hwr, req_pin, grant_pin, pv_rq, pv_gr, pv_oe, pv_pd;
	logic exp_hw;
	logic [2:0] wcyc;
	xhb_pkg::xhb_core_t cg;
	xhb_pkg::xhb_group_t grp, exp_g;
	int seed, mismatches, comparisons, cyc, r;
	int t_rq_r, t_rq_f, t_gr_r, t_gr_f, t_oe_r, t_oe_f, t_pd_f;
	localparam int DRV_MIN = xhb_pkg::EXT_DRIVE_MIN_CYC;
	localparam int DRV_MAX = xhb_pkg::EXT_DRIVE_MAX_CYC;
	// pins resolved from both drivers, pulled low when released
	assign req_pin = rq_oe ? rq_o : (p_rq_oe ? p_rq : 1'b0);
	assign grant_pin = gr_oe ? gr_o : (p_gr_oe ? p_gr : 1'b0);
	xhb_arbiter dut_u (.clk(clk), .resetn(resetn), .strap_internal_arb(s_int),
		.strap_dir_invert(s_inv), .bus_hold_request_i(req_pin),
		.bus_hold_request_o(rq_o), .bus_hold_request_oe(rq_oe),
		.bus_hold_grant_i(grant_pin), .bus_hold_grant_o(gr_o),
		.bus_hold_grant_oe(gr_oe), .shared_control_group_o(grp),
		.shared_control_group_oe(oe), .host_write_read_dir_i(dir_i),
		.core_group(cg), .core_host_port_access(hp),
		.core_xact_pending(pend), .core_want_bus(want),
		.core_hold_off(hold_off), .core_owns_bus(owns),
		.core_host_write(hwr));
	xhb_partner peer_u (.clk(clk), .resetn(resetn), .int_mode(s_int), .go(go),
		.wait_cyc(wcyc), .req_pin(req_pin), .grant_pin(grant_pin),
		.req_drv(p_rq), .req_oe(p_rq_oe), .grant_drv(p_gr),
		.grant_oe(p_gr_oe));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// expected group: mux by access kind, direction by boot polarity
	function automatic xhb_pkg::xhb_group_t grp_of(xhb_pkg::xhb_core_t c,
			logic h, logic inv);
		grp_of = {h ? c.byte_enable_n : c.addr_low, c.addr_strobe_n,
			c.write ^ inv, c.burst_last_n};
	endfunction
	// edge monitor: event times, registered group check, timeout
	always @(posedge clk) begin
		cyc++;
		if (req_pin && !pv_rq) t_rq_r = cyc;
		if (!req_pin && pv_rq) t_rq_f = cyc;
		if (grant_pin && !pv_gr) t_gr_r = cyc;
		if (!grant_pin && pv_gr) t_gr_f = cyc;
		if (oe && !pv_oe) t_oe_r = cyc;
		if (!oe && pv_oe) t_oe_f = cyc;
		if (!pend && pv_pd) t_pd_f = cyc;
		{pv_rq, pv_gr, pv_oe, pv_pd} = {req_pin, grant_pin, oe, pend};
		if (chk_en) begin
			`CHK(grp, exp_g)
			`CHK(hwr, exp_hw)
		end
		exp_g = grp_of(cg, hp, s_inv);
		exp_hw = dir_i ^ s_inv;
		if (cyc > 6000) begin
			mismatches++;
			complete_run();
		end
	end
	// random core values, a small delay after every edge
	always @(posedge clk) begin
		#2;
		r = $random(seed);
		cg = r[10:0];
		{hp, dir_i} = r[12:11];
	end
	task automatic do_reset(input logic im, input logic inv);
		chk_en = 1'b0;
		resetn = 1'b0;
		{s_int, s_inv} = {im, inv};
		repeat (5) @(posedge clk);
		#2 resetn = 1'b1;
		repeat (3) @(posedge clk);
		#2 chk_en = 1'b1;
	endtask
	// outside master takes the bus while we drain a pending transfer
	task automatic int_round();
		int q;
		q = $random(seed);
		wcyc = q[2:0];
		{go, pend} = 2'b11;
		@(posedge clk);
		#2 go = 1'b0;
		repeat (q[5:3]) @(posedge clk);
		#2 pend = 1'b0;
		for (int i = 0; i < 60 && grant_pin !== 1'b1; i++) @(posedge clk);
		`CHK(hold_off, 1'b1)
		`CHK(owns, 1'b0)
		for (int i = 0; i < 60 && !(grant_pin === 1'b0 && oe === 1'b1); i++)
			@(posedge clk);
		repeat (2) @(posedge clk);
		#2;
		`CHK(t_oe_f > t_pd_f, 1'b1)
		`CHK(t_oe_f - t_rq_r >= 3, 1'b1)
		`CHK(t_gr_r - t_oe_f inside {[0:2]}, 1'b1)
		`CHK(t_gr_f - t_rq_f >= 3, 1'b1)
		`CHK(t_oe_r - t_gr_f inside {[0:2]}, 1'b1)
		`CHK(t_rq_f - t_gr_r >= 1, 1'b1)
		`CHK(owns, 1'b1)
		`CHK(hold_off, 1'b0)
	endtask
	// we ask an outside arbiter, drive the group, then give it back
	task automatic ext_round();
		int q;
		q = $random(seed);
		wcyc = q[2:0];
		want = 1'b1;
		for (int i = 0; i < 60 && oe !== 1'b1; i++) @(posedge clk);
		`CHK(owns, 1'b1)
		`CHK(hold_off, 1'b0)
		repeat (q[5:3]) @(posedge clk);
		#2 want = 1'b0;
		for (int i = 0; i < 60 && grant_pin !== 1'b0; i++) @(posedge clk);
		repeat (2) @(posedge clk);
		#2;
		`CHK(t_oe_r - t_gr_r inside {[DRV_MIN:DRV_MAX]}, 1'b1)
		`CHK(t_rq_f - t_oe_f inside {[0:2]}, 1'b1)
		`CHK(oe, 1'b0)
		`CHK(owns, 1'b0)
		`CHK(hold_off, 1'b1)
	endtask
	task automatic complete_run();
		$display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		seed = 93054;
		{mismatches, comparisons, cyc} = '0;
		{resetn, s_int, s_inv, dir_i, hp, pend, want, go, chk_en} = '0;
		{pv_rq, pv_gr, pv_oe, pv_pd, exp_hw} = '0;
		{wcyc, t_rq_r, t_rq_f, t_gr_r, t_gr_f, t_oe_r, t_oe_f, t_pd_f} = '0;
		cg = '0;
		exp_g = '0;
		// every mode with both direction polarities
		for (int m = 0; m < 4; m++) begin
			do_reset(m[0], m[1]);
			for (int k = 0; k < 4; k++) begin
				if (m[0])
					int_round();
				else
					ext_round();
			end
		end
		complete_run();
	end
endmodule
`default_nettype wire

/* File: test/xhb_partner.sv */
// Purpose: far side of the hold handshake: requesting master or arbiter
// Assumes: internal mode means we are the master, else we are the arbiter
// Notes: the released request and grant lines are pulled low by the bench
`timescale 1ns/10ps
`default_nettype none
module xhb_partner (
	input wire logic clk,
	input wire logic resetn,
	input wire logic int_mode,
	input wire logic go,
	input wire logic [2:0] wait_cyc,
	input wire logic req_pin,
	input wire logic grant_pin,
	output logic req_drv,
	output logic req_oe,
	output logic grant_drv,
	output logic grant_oe
);
	logic [3:0] cnt; // periods counted in clk cycles
	// master raises on go and holds past the grant; arbiter grants late
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{req_drv, req_oe, grant_drv, grant_oe} <= 4'h0;
			cnt <= 4'h0;
		end else if (int_mode) begin
			req_oe <= 1'b1;
			grant_oe <= 1'b0;
			if (!req_drv && go) begin
				req_drv <= 1'b1;
				cnt <= 4'h0;
			end else if (req_drv && grant_pin) begin
				// hold at least one period after the grant
				cnt <= cnt + 4'h1;
				if (cnt >= {1'b0, wait_cyc})
					req_drv <= 1'b0;
			end
		end else begin
			req_oe <= 1'b0;
			grant_oe <= 1'b1;
			if (req_pin && !grant_drv) begin
				cnt <= cnt + 4'h1;
				if (cnt >= {1'b0, wait_cyc})
					grant_drv <= 1'b1;
			end else if (!req_pin) begin
				grant_drv <= 1'b0;
				cnt <= 4'h0;
			end
		end
	end
endmodule
`default_nettype wire
